/* File: core/dccw_top.sv */
// Channel control word decoder with its pointer registers and step logic.
//
// Contract
// - Destination step bits 31:30 give 1, 2 or 4 bytes, or 3 for fixed.
// - A fixed destination uses the destination last pointer for every item.
// - Destination width bits 29:28 give 8, 16 or 32 bits, 3 reserved.
// - Source step bits 27:26 give 1, 2 or 4 bytes, or 3 for fixed.
// - A fixed source reads every item from the source last pointer.
// - Source width bits 25:24 give 8, 16 or 32 bits, 3 reserved.
// - Bits 17:14 are an exponent n giving 2**n transfers per grant.
// - Code 0 gives one transfer per grant and code 1 gives two.
// - Codes 10 to 15 give 1024 transfers per grant.
// - Last pointers are the inclusive last address or the fixed address.
//
// The plain strobed port was decided locally.
`timescale 1ns/1ps
module dccw_top
  import dccw_pkg::*;
(
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  input  wire logic [3:0]  i_addr,
  input  wire logic [31:0] i_wdata,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  output logic      [31:0] o_rdata,
  input  wire logic        i_start,
  input  wire logic [9:0]  i_item_index,
  output logic      [31:0] o_src_addr,
  output logic      [31:0] o_dst_addr,
  output logic      [2:0]  o_item_bytes,
  output logic      [10:0] o_arb_count,
  output logic             o_cfg_error,
  output logic             o_start_ok
);

  // ********************************************************************
  // Registers.
  // ********************************************************************
  logic [31:0] src_last;
  logic [31:0] dst_last;
  logic [31:0] ctrl;

  // Register write port; bits 23:18 are stored as written.
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      src_last <= RST_WORD;
      dst_last <= RST_WORD;
      ctrl     <= RST_WORD;
    end else if (i_wr) begin
      if (i_addr == OFF_SRC_LAST) src_last <= i_wdata;
      if (i_addr == OFF_DST_LAST) dst_last <= i_wdata;
      if (i_addr == OFF_CTRL)     ctrl     <= i_wdata;
    end
  end

  // ********************************************************************
  // Field decode.
  // ********************************************************************

  // Step code to byte count, zero meaning a fixed address.
  function automatic logic [2:0] step_bytes(input logic [1:0] code);
    unique case (code)
      2'h0: step_bytes = 3'h1;
      2'h1: step_bytes = 3'h2;
      2'h2: step_bytes = 3'h4;
      2'h3: step_bytes = 3'h0;
    endcase
  endfunction

  // Width code to item byte count, zero meaning reserved.
  function automatic logic [2:0] width_bytes(input logic [1:0] code);
    unique case (code)
      2'h0: width_bytes = 3'h1;
      2'h1: width_bytes = 3'h2;
      2'h2: width_bytes = 3'h4;
      2'h3: width_bytes = 3'h0;
    endcase
  endfunction

  wire logic [1:0] dst_step_code = ctrl[DST_STEP_HI:DST_STEP_LO];
  wire logic [1:0] dst_wid_code  = ctrl[DST_WID_HI:DST_WID_LO];
  wire logic [1:0] src_step_code = ctrl[SRC_STEP_HI:SRC_STEP_LO];
  wire logic [1:0] src_wid_code  = ctrl[SRC_WID_HI:SRC_WID_LO];
  wire logic [3:0] arb_code      = ctrl[ARB_HI:ARB_LO];

  dccw_side_t dst_side;
  dccw_side_t src_side;

  // Decoded step, width and fixed flag for each side.
  assign dst_side.step  = step_bytes(dst_step_code);
  assign dst_side.width = width_bytes(dst_wid_code);
  assign dst_side.fixed = (dst_step_code == STEP_FIXED);
  assign src_side.step  = step_bytes(src_step_code);
  assign src_side.width = width_bytes(src_wid_code);
  assign src_side.fixed = (src_step_code == STEP_FIXED);

  // Reserved width on either side is a configuration error.
  wire logic cfg_err = (dst_wid_code == WID_RSVD) ||
                       (src_wid_code == WID_RSVD);

  // Transfers per arbitration grant, capped at 1024.
  wire logic [10:0] arb_cnt = (arb_code >= ARB_CAP_CODE) ? ARB_CAP_CNT
                            : (11'h001 << arb_code);

  // ********************************************************************
  // Address generation.
  // ********************************************************************

  // Offset back from the last address: (count-1-index)*step is not known
  // here, so the engine supplies the remaining-items index directly.
  wire logic [31:0] src_back = {22'h0, i_item_index} * {29'h0, src_side.step};
  wire logic [31:0] dst_back = {22'h0, i_item_index} * {29'h0, dst_side.step};

  // Addresses count down from the inclusive last pointer; fixed stays put.
  wire logic [31:0] next_src = src_last - src_back;
  wire logic [31:0] next_dst = dst_last - dst_back;

  // Registered outputs for the address and arbitration logic.
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_src_addr   <= RST_WORD;
      o_dst_addr   <= RST_WORD;
      o_item_bytes <= 3'h0;
      o_arb_count  <= 11'h000;
      o_cfg_error  <= 1'b0;
      o_start_ok   <= 1'b0;
    end else begin
      o_src_addr   <= next_src;
      o_dst_addr   <= next_dst;
      o_item_bytes <= src_side.width;
      o_arb_count  <= arb_cnt;
      o_cfg_error  <= cfg_err;
      o_start_ok   <= i_start && !cfg_err;
    end
  end

  // ********************************************************************
  // Read port.
  // ********************************************************************
  wire logic [31:0] status_word = {28'h0, cfg_err, src_side.fixed,
                                   dst_side.fixed, 1'b0};
  wire logic [31:0] rd_mux =
      (i_addr == OFF_SRC_LAST) ? src_last :
      (i_addr == OFF_DST_LAST) ? dst_last :
      (i_addr == OFF_CTRL)     ? ctrl     :
      (i_addr == OFF_STATUS)   ? status_word : RST_WORD;

  // Read data stands in the cycle after the read strobe only.
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_rdata <= RST_WORD;
    end else begin
      o_rdata <= i_rd ? rd_mux : RST_WORD;
    end
  end

  // ********************************************************************
  // Checks.
  // ********************************************************************

  // Antecedents other than p_no_start also want reset low as sampled: the output registers are
  // still cleared at the edge on which reset is released.
  property p_dst_fixed;
    @(posedge i_clk) disable iff (i_rst)
      (!i_rst && dst_side.fixed) |=> (o_dst_addr == $past(dst_last));
  endproperty
  a_dst_fixed: assert property (p_dst_fixed)
    else $error("Fixed destination left the last pointer.");

  property p_src_fixed;
    @(posedge i_clk) disable iff (i_rst)
      (!i_rst && src_side.fixed) |=> (o_src_addr == $past(src_last));
  endproperty
  a_src_fixed: assert property (p_src_fixed)
    else $error("Fixed source left the last pointer.");

  property p_arb_cap;
    @(posedge i_clk) disable iff (i_rst)
      (!i_rst && arb_code >= ARB_CAP_CODE) |=> (o_arb_count == ARB_CAP_CNT);
  endproperty
  a_arb_cap: assert property (p_arb_cap)
    else $error("Capped arbitration count is not 1024.");

  property p_arb_one;
    @(posedge i_clk) disable iff (i_rst)
      (!i_rst && arb_code == 4'h0) |=> (o_arb_count == 11'h001);
  endproperty
  a_arb_one: assert property (p_arb_one)
    else $error("Code zero does not give one transfer.");

  property p_arb_pow;
    @(posedge i_clk) disable iff (i_rst)
      (!i_rst && arb_code < ARB_CAP_CODE) |=>
      (o_arb_count == (11'h001 << $past(arb_code)));
  endproperty
  a_arb_pow: assert property (p_arb_pow)
    else $error("Arbitration count is not a power of two.");

  property p_no_start;
    @(posedge i_clk) disable iff (i_rst)
      (i_start && cfg_err) |=> !o_start_ok;
  endproperty
  a_no_start: assert property (p_no_start)
    else $error("Start passed with a reserved width.");

  property p_dst_step;
    @(posedge i_clk) disable iff (i_rst)
      (!i_rst && dst_step_code == 2'h2) |=>
      (o_dst_addr == $past(dst_last) - {20'h0, $past(i_item_index), 2'h0});
  endproperty
  a_dst_step: assert property (p_dst_step)
    else $error("Destination word step is not four bytes.");

  property p_src_wid;
    @(posedge i_clk) disable iff (i_rst)
      (!i_rst && src_wid_code == 2'h1) |=> (o_item_bytes == 3'h2);
  endproperty
  a_src_wid: assert property (p_src_wid)
    else $error("Half-word source width is not two bytes.");

  sequence s_ctrl_write;
    !i_rst && i_wr && (i_addr == OFF_CTRL);
  endsequence
  property p_ctrl_kept;
    @(posedge i_clk) disable iff (i_rst)
      s_ctrl_write |=> (ctrl == $past(i_wdata));
  endproperty
  a_ctrl_kept: assert property (p_ctrl_kept)
    else $error("Control word not stored as written.");

endmodule

/* File: core/dccw_pkg.sv */
// Package with constants and types for the channel control word decoder.
package dccw_pkg;

  // ********************************************************************
  // Register map.
  // ********************************************************************
  localparam logic [3:0]  OFF_SRC_LAST  = 4'h0;
  localparam logic [3:0]  OFF_DST_LAST  = 4'h4;
  localparam logic [3:0]  OFF_CTRL      = 4'h8;
  localparam logic [3:0]  OFF_STATUS    = 4'hC;
  localparam logic [31:0] RST_WORD      = 32'h0000_0000;

  // ********************************************************************
  // Control word field positions.
  // ********************************************************************
  localparam int DST_STEP_HI  = 31;
  localparam int DST_STEP_LO  = 30;
  localparam int DST_WID_HI   = 29;
  localparam int DST_WID_LO   = 28;
  localparam int SRC_STEP_HI  = 27;
  localparam int SRC_STEP_LO  = 26;
  localparam int SRC_WID_HI   = 25;
  localparam int SRC_WID_LO   = 24;
  localparam int ARB_HI       = 17;
  localparam int ARB_LO       = 14;

  // ********************************************************************
  // Encodings.
  // ********************************************************************
  localparam logic [1:0]  STEP_FIXED   = 2'h3;
  localparam logic [1:0]  WID_RSVD     = 2'h3;
  localparam logic [3:0]  ARB_CAP_CODE = 4'hA;
  localparam logic [10:0] ARB_CAP_CNT  = 11'h400;

  // Decoded per-side addressing settings.
  typedef struct packed {
    logic [2:0] step;
    logic [2:0] width;
    logic       fixed;
  } dccw_side_t;

endpackage

/* File: testbench/dccw_sw_table.sv */
// Software model that composes legal channel control words.
`timescale 1ns/1ps
module dccw_sw_table
  import dccw_pkg::*;
(
  input  wire logic [1:0]  i_wid,
  input  wire logic [1:0]  i_sstep,
  input  wire logic [1:0]  i_dstep,
  input  wire logic [3:0]  i_arb,
  input  wire logic [5:0]  i_kept,
  output logic      [31:0] o_word
);
  logic [1:0] sstep;
  logic [1:0] dstep;

  // Steps narrower than the item are raised to the item width.
  assign sstep = (i_sstep != STEP_FIXED && i_sstep < i_wid) ? i_wid
               : i_sstep;
  assign dstep = (i_dstep != STEP_FIXED && i_dstep < i_wid) ? i_wid
               : i_dstep;
  // Both widths match and the reserved bits keep their read-back value.
  assign o_word = {dstep, i_wid, sstep, i_wid, i_kept, i_arb,
                   14'h0000};
endmodule

/* File: testbench/test_dccw_top.sv */
// Self-checking testbench for the channel control word decoder.
`timescale 1ns/1ps
module test_dccw_top
  import dccw_pkg::*;
;
  logic        i_clk = 1'b0;
  logic        i_rst = 1'b1;
  logic [3:0]  i_addr = 4'h0;
  logic [31:0] i_wdata = 32'h0;
  logic        i_wr = 1'b0;
  logic        i_rd = 1'b0;
  logic        i_start = 1'b0;
  logic [9:0]  i_item_index = 10'h005;
  logic [31:0] o_rdata, o_src_addr, o_dst_addr, word;
  logic [2:0]  o_item_bytes;
  logic [10:0] o_arb_count;
  logic        o_cfg_error, o_start_ok;
  logic [1:0]  wid = 2'h0, sstep = 2'h0, dstep = 2'h0;
  logic [3:0]  arb = 4'h0;
  logic [5:0]  kept = 6'h00;
  int          err_total = 0;
  int          n_compared = 0;

  // Clock of 4 ns period.
  always #2 i_clk = ~i_clk;

  dccw_top dccw_top_inst (.i_clk(i_clk), .i_rst(i_rst), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .i_start(i_start), .i_item_index(i_item_index),
    .o_src_addr(o_src_addr), .o_dst_addr(o_dst_addr),
    .o_item_bytes(o_item_bytes), .o_arb_count(o_arb_count),
    .o_cfg_error(o_cfg_error), .o_start_ok(o_start_ok));
  dccw_sw_table dccw_sw_table_inst (.i_wid(wid), .i_sstep(sstep),
    .i_dstep(dstep), .i_arb(arb), .i_kept(kept), .o_word(word));

  // Compares one value and reports a mismatch at once.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One write cycle on the register port.
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge i_clk);
    i_addr  <= a;
    i_wdata <= d;
    i_wr    <= 1'b1;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask

  // One read cycle; the data stand only in the following cycle.
  task automatic rd(input logic [3:0] a, input logic [31:0] exp);
    @(posedge i_clk);
    i_addr <= a;
    i_rd   <= 1'b1;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1 chk(o_rdata, exp);
  endtask

  // Writes the modelled control word and waits for the decoded outputs.
  task automatic put_word;
    #1 wr(OFF_CTRL, word);
    repeat (2) @(posedge i_clk);
    #1;
  endtask

  function automatic logic [31:0] stepb(input int c);
    return (c == 3) ? 32'h0 : 32'h1 << c;
  endfunction

  // Reset value, unmapped place, read-only status and kept spare bits.
  task automatic t_regs;
    rd(OFF_CTRL, RST_WORD);
    wr(4'h2, 32'hFFFF_FFFF);
    rd(4'h2, 32'h0);
    wr(OFF_STATUS, 32'hFFFF_FFFF);
    rd(OFF_STATUS, 32'h0);
    wr(OFF_CTRL, 32'h00FC_3FFF);
    rd(OFF_CTRL, 32'h00FC_3FFF);
    kept = 6'h3F;
  endtask

  // Every step code on both sides, counted back from the last pointers.
  task automatic t_steps;
    wr(OFF_SRC_LAST, 32'h0000_1000);
    wr(OFF_DST_LAST, 32'h0000_2000);
    for (int c = 0; c < 4; c++) begin
      sstep = c[1:0];
      dstep = 2'(3 - c);
      put_word;
      chk(o_src_addr, 32'h1000 - 5 * stepb(c));
      chk(o_dst_addr, 32'h2000 - 5 * stepb(3 - c));
    end
  endtask

  // Each legal item width, with the steps raised to match it.
  task automatic t_widths;
    sstep = 2'h0;
    dstep = 2'h0;
    for (int w = 0; w < 3; w++) begin
      wid = w[1:0];
      put_word;
      chk({29'h0, o_item_bytes}, 32'h1 << w);
      chk(o_dst_addr, 32'h2000 - 5 * stepb(w));
      chk({31'h0, o_cfg_error}, 32'h0);
    end
  endtask

  // Every re-arbitration code, including the capped ones.
  task automatic t_arb;
    for (int a = 0; a < 16; a++) begin
      arb = a[3:0];
      put_word;
      chk({21'h0, o_arb_count}, a > 9 ? 32'h400 : 32'h1 << a);
    end
  endtask

  // A reserved width blocks the start; a legal one lets it through.
  task automatic t_error;
    @(posedge i_clk);
    i_start <= 1'b1;
    wid = 2'h3;
    put_word;
    chk({30'h0, o_cfg_error, o_start_ok}, 32'h2);
    rd(OFF_STATUS, 32'hE);
    wid = 2'h1;
    put_word;
    chk({30'h0, o_cfg_error, o_start_ok}, 32'h1);
    rd(OFF_CTRL, word);
  endtask

  // A reset in mid-run clears the control and destination last registers and every decoded output.
  task automatic t_reset;
    @(posedge i_clk);
    i_rst <= 1'b1;
    repeat (2) @(posedge i_clk);
    #1 chk(o_src_addr, RST_WORD);
    chk(o_dst_addr, RST_WORD);
    chk({21'h0, o_arb_count}, 32'h0);
    chk({27'h0, o_item_bytes, o_cfg_error, o_start_ok}, 32'h0);
    @(posedge i_clk);
    i_rst <= 1'b0;
    rd(OFF_CTRL, RST_WORD);
    rd(OFF_DST_LAST, RST_WORD);
    chk({31'h0, o_start_ok}, 32'h1);
  endtask

  // Prints the verdict and ends the run.
  task automatic complete_run;
    if (err_total == 0 && n_compared > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // Main sequence after three cycles of reset.
  initial begin
    repeat (3) @(posedge i_clk);
    i_rst <= 1'b0;
    t_regs;
    t_steps;
    t_widths;
    t_arb;
    t_error;
    t_reset;
    complete_run;
  end

  // Watchdog against a hang.
  initial begin
    #20000;
    err_total++;
    complete_run;
  end
endmodule
